//--- hdl/hdcf_pkg.sv
// Constants shared by the host debug code FIFO and its storage buffer.
// Assumes a single clock domain with a synchronous, active-high reset.
package hdcf_pkg;
   // Register offsets from the instance base (controller view)
   localparam logic [11:0] OFS_HOST = 12'h000;
   localparam logic [11:0] OFS_POP = 12'h100;
   localparam logic [11:0] OFS_CFG = 12'h104;
   localparam logic [11:0] OFS_STAT = 12'h108;
   localparam logic [11:0] OFS_CNT = 12'h10C;
   // Entry layout: timestamp above the code byte
   localparam int CODE_W = 8;
   localparam int TS_W = 24;
   localparam int ENTRY_W = 32;
   localparam int FIFO_DEPTH = 16;
   localparam int CNT_W = 5;
   localparam int CNT_LSB = 8;
   // Configuration field positions
   localparam int CFG_THR_LSB = 6;
   localparam int CFG_RUN_BIT = 5;
   localparam int CFG_TICK_LSB = 3;
   localparam int CFG_CLR_BIT = 2;
   localparam int CFG_FLUSH_BIT = 1;
   // Status field positions
   localparam int STAT_LOST_BIT = 1;
   localparam int STAT_HAS_BIT = 0;
   // Reset values of the configuration fields
   localparam logic [1:0] THR_RST = 2'h0;
   localparam logic [1:0] TICK_RST = 2'h0;
   localparam logic RUN_RST = 1'b0;
   // Fill thresholds per code
   localparam logic [CNT_W-1:0] THR_C0 = 5'h01;
   localparam logic [CNT_W-1:0] THR_C1 = 5'h04;
   localparam logic [CNT_W-1:0] THR_C2 = 5'h08;
   localparam logic [CNT_W-1:0] THR_C3 = 5'h0E;
   // Tick divider masks (divide minus one) per code
   localparam logic [5:0] DIV_M0 = 6'h07;
   localparam logic [5:0] DIV_M1 = 6'h0F;
   localparam logic [5:0] DIV_M2 = 6'h1F;
   localparam logic [5:0] DIV_M3 = 6'h3F;
endpackage

//--- hdl/hdcf_fifo.sv
// Storage buffer for captured debug codes, width and depth as parameters.
// Assumes one clock; a push into a full buffer is taken only when the
// drain side pops in the same cycle, which lets the owner drop the oldest.
`timescale 1ns/10ps
module hdcf_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16,
   parameter int AW = $clog2(DEPTH)
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // Control and level
   input wire logic flush,
   output logic [AW:0] level
);
   localparam logic [AW:0] FULL_LVL = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST = (AW)'(DEPTH-1);

   logic [WIDTH-1:0] mem [DEPTH];  // Entry storage
   logic [AW-1:0] wr_ptr;  // Next slot to fill
   logic [AW-1:0] rd_ptr;  // Oldest slot
   logic push;
   logic pop;

   // Full stalls the source unless the drain frees a slot now
   assign in_ready = (level != FULL_LVL) || out_ready;
   assign out_valid = (level != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Storage write; no reset needed on the array
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // Pointers and level; flush wins over any traffic
   always_ff @(posedge clk) begin
      if (srst || flush) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
         end
         // Level moves only when exactly one side moves
         if (push && !pop) begin
            level <= level + 1'b1;
         end else if (pop && !push) begin
            level <= level - 1'b1;
         end
      end
   end
endmodule

//--- hdl/hdcf_top.sv
// Host debug code FIFO: host byte writes tagged with a timestamp and queued
// for the embedded controller, with timer, threshold and status registers.
// Assumes host bus decoders and the controller port run on clk; all their
// strobes are single-cycle and already synchronous, so none are resynced.
`timescale 1ns/10ps
module hdcf_top (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Host I/O write strobes and address
   input wire logic lpc_io_wr,
   input wire logic espi_io_wr,
   input wire logic espi_io_word,
   input wire logic [15:0] host_io_addr,
   input wire logic [15:0] host_io_wdata,
   input wire logic [15:0] host_base_addr,
   // Controller register port
   input wire logic ec_req,
   input wire logic ec_we,
   input wire logic [11:0] ec_addr,
   input wire logic [3:0] ec_be,
   input wire logic [31:0] ec_wdata,
   output logic ec_ack,
   output logic [31:0] ec_rdata,
   // Interrupt to the controller
   output logic debug_port_irq
);
   localparam int AW = $clog2(hdcf_pkg::FIFO_DEPTH);

   // Decode a controller access against one register offset
   function automatic logic ec_hit(input logic [11:0] addr, input logic [11:0] ofs);
      ec_hit = (addr[11:2] == ofs[11:2]);
   endfunction

   // threshold code decode
   // Map the threshold code to an entry count
   function automatic logic [hdcf_pkg::CNT_W-1:0] thr_of(input logic [1:0] code);
      unique case (code)
         2'h0: thr_of = hdcf_pkg::THR_C0;
         2'h1: thr_of = hdcf_pkg::THR_C1;
         2'h2: thr_of = hdcf_pkg::THR_C2;
         2'h3: thr_of = hdcf_pkg::THR_C3;
      endcase
   endfunction

   // Map the tick select code to a divider mask
   function automatic logic [5:0] div_of(input logic [1:0] code);
      unique case (code)
         2'h0: div_of = hdcf_pkg::DIV_M0;
         2'h1: div_of = hdcf_pkg::DIV_M1;
         2'h2: div_of = hdcf_pkg::DIV_M2;
         2'h3: div_of = hdcf_pkg::DIV_M3;
      endcase
   endfunction

   // Configuration state
   logic [1:0] fill_thr_code;  // Interrupt threshold code
   logic timer_run;  // Timestamp counter running
   logic [1:0] tick_divider_choice;  // Counter tick rate
   // Status and timer state
   logic lost_write;  // Sticky overrun flag
   logic [hdcf_pkg::TS_W-1:0] capture_time;  // Timestamp, counts only while run
   logic [5:0] div_cnt;  // Tick prescaler
   // Decoded controller accesses
   logic ec_wr;
   logic ec_rd;
   logic wr_host;
   logic wr_cfg;
   logic wr_cnt;
   logic rd_pop;
   // Host capture path
   logic host_lo;  // Byte aimed at this instance, low lane
   logic host_hi;  // Upper byte of an eSPI word aimed one below
   logic push_req;
   logic [hdcf_pkg::CODE_W-1:0] push_byte;
   logic [hdcf_pkg::ENTRY_W-1:0] push_entry;
   // Buffer handshake
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [hdcf_pkg::ENTRY_W-1:0] fifo_out_data;
   logic [AW:0] fifo_level;
   logic fifo_full;
   logic drop_oldest;
   logic do_pop;
   // Timer controls
   logic do_flush;
   logic do_clear;
   logic do_load;
   logic tick;
   logic [hdcf_pkg::TS_W-1:0] next_time;

   // Controller strobes
   assign ec_wr = ec_req && ec_we;
   assign ec_rd = ec_req && !ec_we;
   assign wr_cfg = ec_wr && ec_hit(ec_addr, hdcf_pkg::OFS_CFG);
   assign wr_cnt = ec_wr && ec_hit(ec_addr, hdcf_pkg::OFS_CNT);
   assign rd_pop = ec_rd && ec_hit(ec_addr, hdcf_pkg::OFS_POP);
   // data at zero; controller may write it too
   assign wr_host = ec_wr && ec_hit(ec_addr, hdcf_pkg::OFS_HOST) && ec_be[0];

   // LPC and eSPI byte writes at the base
   assign host_lo = (lpc_io_wr || espi_io_wr) && (host_io_addr == host_base_addr);
   // eSPI word: the second byte belongs to base
   assign host_hi = espi_io_wr && espi_io_word
                    && ((host_io_addr + 16'h0001) == host_base_addr);

   // Pick the byte to push; host and controller never collide in practice,
   // the host lane is preferred if they do
   always_comb begin
      push_req = host_lo || host_hi || wr_host;
      if (host_lo) begin
         push_byte = host_io_wdata[7:0];
      end else if (host_hi) begin
         push_byte = host_io_wdata[15:8];
      end else begin
         push_byte = ec_wdata[7:0];
      end
   end

   assign push_entry = {capture_time, push_byte};

   assign fifo_full = (fifo_level == (AW+1)'(hdcf_pkg::FIFO_DEPTH));
   assign drop_oldest = push_req && fifo_full;
   assign do_pop = rd_pop && fifo_out_valid;
   assign fifo_out_ready = do_pop || drop_oldest;

   assign do_flush = wr_cfg && ec_be[0] && ec_wdata[hdcf_pkg::CFG_FLUSH_BIT];

   hdcf_fifo #(
      .WIDTH(hdcf_pkg::ENTRY_W),
      .DEPTH(hdcf_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .srst(srst),
      .in_valid(push_req),
      .in_ready(fifo_in_ready),
      .in_data(push_entry),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data),
      .flush(do_flush),
      .level(fifo_level)
   );

   // Configuration fields, low byte lane only
   always_ff @(posedge clk) begin
      if (srst) begin
         fill_thr_code <= hdcf_pkg::THR_RST;
         timer_run <= hdcf_pkg::RUN_RST;
         tick_divider_choice <= hdcf_pkg::TICK_RST;
      end else if (wr_cfg && ec_be[0]) begin
         fill_thr_code <= ec_wdata[hdcf_pkg::CFG_THR_LSB +: 2];
         timer_run <= ec_wdata[hdcf_pkg::CFG_RUN_BIT];
         tick_divider_choice <= ec_wdata[hdcf_pkg::CFG_TICK_LSB +: 2];
      end
   end

   // sticky until flush; set beats the flush clear
   always_ff @(posedge clk) begin
      if (srst) begin
         lost_write <= 1'b0;
      end else if (drop_oldest) begin
         lost_write <= 1'b1;
      end else if (do_flush) begin
         lost_write <= 1'b0;
      end
   end

   // prescaler mask per select
   // Prescaler stops with the timer so a restart begins a full period
   always_ff @(posedge clk) begin
      if (srst || !timer_run) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + 6'h01;
      end
   end
   assign tick = timer_run
                 && ((div_cnt & div_of(tick_divider_choice)) == div_of(tick_divider_choice));

   assign do_clear = (wr_cfg && ec_be[0] && ec_wdata[hdcf_pkg::CFG_CLR_BIT])
                     || (wr_cnt && (ec_wdata == 32'h0000_0000));
   assign do_load = wr_cnt && (ec_be[3:1] != 3'h0);

   // load merges the written byte lanes
   always_comb begin
      next_time = capture_time;
      for (int i = 1; i < 4; i++) begin
         if (ec_be[i]) begin
            next_time[(i-1)*8 +: 8] = ec_wdata[i*8 +: 8];
         end
      end
   end

   // counts while run, else holds
   // Software writes win over a tick landing in the same cycle
   always_ff @(posedge clk) begin
      if (srst || do_clear) begin
         capture_time <= '0;
      end else if (do_load) begin
         capture_time <= next_time;
      end else if (tick) begin
         capture_time <= capture_time + 24'h00_0001;
      end
   end

   // Controller read data, registered; unmapped and write-only read zero
   always_ff @(posedge clk) begin
      if (srst) begin
         ec_rdata <= 32'h0000_0000;
      end else if (ec_rd) begin
         ec_rdata <= 32'h0000_0000;
         if (ec_hit(ec_addr, hdcf_pkg::OFS_POP) && fifo_out_valid) begin
            ec_rdata <= fifo_out_data;
         end else if (ec_hit(ec_addr, hdcf_pkg::OFS_CFG)) begin
            ec_rdata[hdcf_pkg::CFG_THR_LSB +: 2] <= fill_thr_code;
            ec_rdata[hdcf_pkg::CFG_RUN_BIT] <= timer_run;
            ec_rdata[hdcf_pkg::CFG_TICK_LSB +: 2] <= tick_divider_choice;
         end else if (ec_hit(ec_addr, hdcf_pkg::OFS_STAT)) begin
            ec_rdata[hdcf_pkg::STAT_HAS_BIT] <= fifo_out_valid;
            ec_rdata[hdcf_pkg::STAT_LOST_BIT] <= lost_write;
         end else if (ec_hit(ec_addr, hdcf_pkg::OFS_CNT)) begin
            ec_rdata[hdcf_pkg::CNT_LSB +: hdcf_pkg::TS_W] <= capture_time;
         end
      end
   end

   // Every controller access is answered one cycle later
   always_ff @(posedge clk) begin
      if (srst) begin
         ec_ack <= 1'b0;
      end else begin
         ec_ack <= ec_req;
      end
   end

   // irq at or above threshold
   // Registered, so it trails the level by one cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         debug_port_irq <= 1'b0;
      end else begin
         debug_port_irq <= (fifo_level >= thr_of(fill_thr_code));
      end
   end

   // Checks
   sequence s_full_write;
      push_req && fifo_full && !do_flush;
   endsequence

   sequence s_pop_read;
      rd_pop && fifo_out_valid;
   endsequence

   AST_THRESHOLD: assert property (@(posedge clk) disable iff (srst)
      (fill_thr_code == 2'h3 && $stable(fill_thr_code) && fifo_level == 5'h0D)
      |=> !debug_port_irq)
      else $error("irq raised below fourteen entries");

   AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (srst)
      debug_port_irq == ($past(fifo_level) >= thr_of($past(fill_thr_code))))
      else $error("irq does not follow fill level");

   AST_RUN_HOLD: assert property (@(posedge clk) disable iff (srst)
      (!timer_run && !wr_cnt && !wr_cfg) |=> $stable(capture_time))
      else $error("timestamp moved while stopped");

   AST_TICK_DIV8: assert property (@(posedge clk) disable iff (srst)
      (timer_run && tick_divider_choice == 2'h0
       && !wr_cnt && !wr_cfg) [*8] |=> (capture_time == $past(capture_time, 8) + 24'h00_0001))
      else $error("timestamp did not advance once per eight cycles");

   AST_CLEAR: assert property (@(posedge clk) disable iff (srst)
      (wr_cfg && ec_be[0] && ec_wdata[hdcf_pkg::CFG_CLR_BIT]) |=> capture_time == '0)
      else $error("clear bit did not zero timestamp");

   AST_ZERO_WRITE: assert property (@(posedge clk) disable iff (srst)
      (wr_cnt && ec_wdata == 32'h0000_0000) |=> capture_time == '0)
      else $error("zero count write did not clear");

   AST_FLUSH: assert property (@(posedge clk) disable iff (srst)
      do_flush |=> fifo_level == '0 ##1 !(ec_rdata[hdcf_pkg::CFG_FLUSH_BIT] && $past(ec_rd)
      && ec_hit($past(ec_addr), hdcf_pkg::OFS_CFG)))
      else $error("flush did not empty buffer");

   AST_LOST_SET: assert property (@(posedge clk) disable iff (srst)
      s_full_write |=> lost_write && fifo_full)
      else $error("write into full buffer not flagged");

   AST_LOST_STICKY: assert property (@(posedge clk) disable iff (srst)
      (lost_write && !do_flush) |=> lost_write)
      else $error("lost flag dropped without flush");

   AST_DROP_OLDEST: assert property (@(posedge clk) disable iff (srst)
      s_full_write |-> fifo_in_ready && fifo_out_ready)
      else $error("full write not taken by dropping oldest");

   AST_POP_DATA: assert property (@(posedge clk) disable iff (srst)
      s_pop_read |=> ec_ack && ec_rdata == $past(fifo_out_data))
      else $error("popped word not returned");

   AST_POP_EMPTY: assert property (@(posedge clk) disable iff (srst)
      (rd_pop && !fifo_out_valid && !push_req) |=> ec_rdata == '0 && fifo_level == '0)
      else $error("empty read not zero");

   AST_ENTRY: assert property (@(posedge clk) disable iff (srst)
      (host_lo && !fifo_full && !fifo_out_valid && !do_flush)
      |=> fifo_out_data == {$past(capture_time), $past(host_io_wdata[7:0])})
      else $error("entry layout wrong");
endmodule

//--- dv/hdcf_bus_model.sv
// Model of the host I/O bus and the embedded controller port of the FIFO.
// Assumes the design samples on the rising edge; this model drives on falling.
`timescale 1ns/10ps
module hdcf_bus_model (
   // Clock
   input wire logic clk,
   // Host write side
   output logic lpc_io_wr,
   output logic espi_io_wr,
   output logic espi_io_word,
   output logic [15:0] host_io_addr,
   output logic [15:0] host_io_wdata,
   // Controller port
   output logic ec_req,
   output logic ec_we,
   output logic [11:0] ec_addr,
   output logic [3:0] ec_be,
   output logic [31:0] ec_wdata,
   input wire logic ec_ack,
   input wire logic [31:0] ec_rdata
);
   // Idle bus at time zero
   initial begin
      lpc_io_wr = 1'b0;
      espi_io_wr = 1'b0;
      espi_io_word = 1'b0;
      host_io_addr = 16'hFFFF;
      host_io_wdata = 16'hFFFF;
      ec_req = 1'b0;
      ec_we = 1'b0;
      ec_addr = 12'hFFF;
      ec_be = 4'h0;
      ec_wdata = 32'hFFFFFFFF;
   end

   // One-cycle host strobe; released lines flip so stale data never matches
   // byte or word
   task automatic host_wr(input logic espi, input logic word, input logic [15:0] addr,
      input logic [15:0] data);
      @(negedge clk);
      lpc_io_wr = ~espi;
      espi_io_wr = espi;
      espi_io_word = espi & word;
      host_io_addr = addr;
      host_io_wdata = data;
      @(negedge clk);
      lpc_io_wr = 1'b0;
      espi_io_wr = 1'b0;
      espi_io_word = 1'b0;
      host_io_addr = ~addr;
      host_io_wdata = ~data;
      @(posedge clk);
   endtask

   // Controller access: one-cycle request, answer taken while ack stands
   task automatic ec_acc(input logic we, input logic [11:0] addr, input logic [31:0] wd,
      output logic [31:0] rd, output logic acked);
      @(negedge clk);
      ec_req = 1'b1;
      ec_we = we;
      ec_addr = addr;
      ec_be = 4'hF;
      ec_wdata = wd;
      // Ack and read data stand from the taking edge to the next rising edge
      @(negedge clk);
      acked = ec_ack;
      rd = ec_rdata;
      // Drop the request before the next edge so it is taken only once
      ec_req = 1'b0;
      ec_addr = ~addr;
      ec_wdata = ~wd;
   endtask
endmodule

//--- dv/hdcf_top_test.sv
// Self-checking bench for the host debug code FIFO top level.
// Assumes the bus model in hdcf_bus_model and an instance base of 0x0080.
`timescale 1ns/10ps
module hdcf_top_test;
   // Clock, reset and bus wires
   logic clk, srst, irq, ack;
   logic lpc_io_wr, espi_io_wr, espi_io_word, ec_req, ec_we, ec_ack;
   logic [15:0] host_io_addr, host_io_wdata;
   logic [11:0] ec_addr;
   logic [3:0] ec_be;
   logic [31:0] ec_wdata, ec_rdata, rd;
   // Result counters
   int bad_count = 0;
   int n_checks = 0;

   hdcf_top DUT (.clk(clk), .srst(srst), .lpc_io_wr(lpc_io_wr), .espi_io_wr(espi_io_wr),
      .espi_io_word(espi_io_word), .host_io_addr(host_io_addr),
      .host_io_wdata(host_io_wdata), .host_base_addr(16'h0080), .ec_req(ec_req),
      .ec_we(ec_we), .ec_addr(ec_addr), .ec_be(ec_be), .ec_wdata(ec_wdata),
      .ec_ack(ec_ack), .ec_rdata(ec_rdata), .debug_port_irq(irq));
   hdcf_bus_model bus (.clk(clk), .lpc_io_wr(lpc_io_wr), .espi_io_wr(espi_io_wr),
      .espi_io_word(espi_io_word), .host_io_addr(host_io_addr),
      .host_io_wdata(host_io_wdata), .ec_req(ec_req), .ec_we(ec_we), .ec_addr(ec_addr),
      .ec_be(ec_be), .ec_wdata(ec_wdata), .ec_ack(ec_ack), .ec_rdata(ec_rdata));

   // Free-running 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Compare and count
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Register write and read; every access must be acknowledged
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus.ec_acc(1'b1, a, d, rd, ack);
      check({31'h0, ack}, 32'h1);
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      bus.ec_acc(1'b0, a, 32'h0, rd, ack);
      check({31'h0, ack}, 32'h1);
      check(rd, exp);
   endtask

   // Every register reads its reset value; unmapped and host offsets read zero
   task automatic t_reset;
      check({31'h0, irq}, 32'h0);
      rd_chk(12'h108, 32'h0);
      rd_chk(12'h104, 32'h0);
      rd_chk(12'h10C, 32'h0);
      rd_chk(12'h100, 32'h0);
      rd_chk(12'h000, 32'h0);
      rd_chk(12'h200, 32'h0);
   endtask

   // Entries carry the loaded stamp; foreign address ignored; empty pop is zero
   task automatic t_stamp;
      wr(12'h10C, 32'hABCDEF00);
      rd_chk(12'h10C, 32'hABCDEF00);
      bus.host_wr(1'b0, 1'b0, 16'h0080, 16'h0012);
      bus.host_wr(1'b0, 1'b0, 16'h0081, 16'h0077);
      wr(12'h000, 32'h00000034);
      rd_chk(12'h108, 32'h1);
      rd_chk(12'h100, 32'hABCDEF12);
      rd_chk(12'h100, 32'hABCDEF34);
      rd_chk(12'h100, 32'h0);
      rd_chk(12'h108, 32'h0);
   endtask

   // Both ways of clearing the counter
   task automatic t_clear;
      wr(12'h10C, 32'h00001100);
      wr(12'h104, 32'h4);
      rd_chk(12'h10C, 32'h0);
      rd_chk(12'h104, 32'h0);
      wr(12'h10C, 32'h00002200);
      wr(12'h10C, 32'h0);
      rd_chk(12'h10C, 32'h0);
   endtask

   // Run three and a half ticks per divider, then stop; count must hold
   task automatic t_timer;
      int div;
      for (int c = 0; c < 4; c++) begin
         div = 8 << c;
         wr(12'h10C, 32'h0);
         wr(12'h104, 32'h20 | (c << 3));
         repeat (div * 3 + div / 2 - 2) @(posedge clk);
         wr(12'h104, c << 3);
         rd_chk(12'h10C, 32'h300);
         repeat (100) @(posedge clk);
         rd_chk(12'h10C, 32'h300);
      end
   endtask

   // Interrupt rises exactly when the level reaches each threshold
   task automatic t_thresh;
      int thr[4] = '{1, 4, 8, 14};
      for (int c = 0; c < 4; c++) begin
         wr(12'h104, (c << 6) | 32'h2);
         repeat (thr[c] - 1) bus.host_wr(1'b0, 1'b0, 16'h0080, 16'h0055);
         repeat (2) @(negedge clk);
         check({31'h0, irq}, 32'h0);
         bus.host_wr(1'b0, 1'b0, 16'h0080, 16'h0055);
         repeat (2) @(negedge clk);
         check({31'h0, irq}, 32'h1);
      end
   endtask

   // Sixteen fit, the seventeenth drops the oldest and sticks the lost flag
   task automatic t_overrun;
      wr(12'h10C, 32'h0);
      wr(12'h104, 32'h2);
      for (int i = 0; i < 16; i++) bus.host_wr(1'b1, 1'b0, 16'h0080, i);
      rd_chk(12'h108, 32'h1);
      bus.host_wr(1'b0, 1'b0, 16'h0080, 16'h0010);
      rd_chk(12'h108, 32'h3);
      for (int i = 1; i < 17; i++) rd_chk(12'h100, i);
      rd_chk(12'h108, 32'h2);
      wr(12'h104, 32'h2);
      rd_chk(12'h108, 32'h0);
      rd_chk(12'h104, 32'h0);
   endtask

   // Word writes: only the byte whose address hits the base is taken
   task automatic t_espi;
      bus.host_wr(1'b1, 1'b1, 16'h007F, 16'hA55A);
      bus.host_wr(1'b1, 1'b1, 16'h0080, 16'h3CC3);
      bus.host_wr(1'b1, 1'b1, 16'h007E, 16'h1111);
      rd_chk(12'h100, 32'hA5);
      rd_chk(12'h100, 32'hC3);
      rd_chk(12'h100, 32'h0);
   endtask

   // Verdict and end of run
   task automatic close_out;
      $display("Checks %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Hang guard: the whole sequence needs under two thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      close_out;
   end

   // Main sequence: reset three cycles, then the scenarios
   initial begin
      srst = 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      srst = 1'b0;
      t_reset;
      t_stamp;
      t_clear;
      t_timer;
      t_thresh;
      t_overrun;
      t_espi;
      close_out;
   end
endmodule
